// >>> logic/dag_gate.sv
// Debug authentication gate: turns four permission inputs into enables for the four debug levels,
// and adds two secure user settings to make the enables for the current mode.
// Assumes the permission inputs are driven by system-level logic and are
// synchronous to core_clk; the user settings come from secure software.
`timescale 1ns/1ps
`include "dag_regs.svh"

module dag_gate #(
    parameter dag_pkg::dag_mode_t MODE = dag_pkg::DAG_MODE_SYNC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Permission inputs from system logic
    input  wire logic invasive_permit_in,
    input  wire logic noninvasive_permit_in,
    input  wire logic secure_invasive_permit_in,
    input  wire logic secure_noninvasive_permit_in,
    // Secure user-mode settings held by secure software
    input  wire logic secure_user_invasive_permit,
    input  wire logic secure_user_noninvasive_permit,
    // Current processor mode of the traced or debugged context
    input  wire logic secure_mode,
    input  wire logic user_mode,
    // Level enables
    output logic      ns_invasive_en,
    output logic      ns_noninvasive_en,
    output logic      s_invasive_en,
    output logic      s_noninvasive_en,
    output logic      sampled_valid,
    // Enables for the current mode
    output logic      cur_invasive_en,
    output logic      cur_noninvasive_en
);

    // Only two modes exist and the level vector must match the field map; refuse anything else
    if (MODE != dag_pkg::DAG_MODE_SYNC && MODE != dag_pkg::DAG_MODE_ASYNC) begin : g_bad_mode
        $error("dag_gate: unsupported sampling mode");
    end
    if ($bits(dag_pkg::dag_levels_t) != `DAG_LVL_WIDTH) begin : g_bad_width
        $error("dag_gate: level vector width differs from the field map");
    end

    // Sampling flavour as a constant, so each check below can pick its own timing
    localparam bit IS_SYNC = (MODE == dag_pkg::DAG_MODE_SYNC);

    // Derive level enables from the four permits
    function automatic dag_pkg::dag_levels_t calc_levels(input logic inv, input logic nin,
                                                          input logic sinv, input logic snin);
        logic eff_nin;
        logic eff_snin;
        dag_pkg::dag_levels_t lv;
        eff_nin  = inv | nin;
        eff_snin = sinv | snin;
        lv = `DAG_RST_LEVELS;
        lv[`DAG_LVL_NS_INV]    = inv;
        lv[`DAG_LVL_NS_NONINV] = eff_nin;
        lv[`DAG_LVL_S_INV]     = inv & sinv;
        lv[`DAG_LVL_S_NONINV]  = eff_nin & eff_snin;
        return lv;
    endfunction

    dag_pkg::dag_levels_t raw_lv;
    dag_pkg::dag_levels_t lv_q;
    logic                 valid_q;
    dag_pkg::dag_levels_t lv;

    // Combinational view of the inputs, used directly in async mode
    always_comb begin
        raw_lv = calc_levels(invasive_permit_in, noninvasive_permit_in,
                             secure_invasive_permit_in, secure_noninvasive_permit_in);
    end

    // Sample the permits; a change takes effect one edge later, which is allowed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lv_q <= `DAG_RST_LEVELS;
        end else begin
            lv_q <= raw_lv;
        end
    end

    // First sample marker; in sync mode enables stay low before it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= `DAG_RST_BIT;
        end else begin
            valid_q <= 1'b1;
        end
    end

    // Select async or sampled path; async path is still gated during reset
    always_comb begin
        if (MODE == dag_pkg::DAG_MODE_SYNC) begin
            lv = valid_q ? lv_q : `DAG_RST_LEVELS;
        end else begin
            lv = arst_n ? raw_lv : `DAG_RST_LEVELS;
        end
    end

    assign ns_invasive_en    = lv[`DAG_LVL_NS_INV];
    assign ns_noninvasive_en = lv[`DAG_LVL_NS_NONINV];
    assign s_invasive_en     = lv[`DAG_LVL_S_INV];
    assign s_noninvasive_en  = lv[`DAG_LVL_S_NONINV];
    assign sampled_valid     = (MODE == dag_pkg::DAG_MODE_SYNC) ? valid_q : arst_n;

    // Secure user mode may borrow the user settings, but never beyond the
    // non-secure bound; secure privileged modes get only the full secure permit.
    // Software-only debug functions are not routed through here at all.
    always_comb begin
        if (!secure_mode) begin
            cur_invasive_en    = lv[`DAG_LVL_NS_INV];
            cur_noninvasive_en = lv[`DAG_LVL_NS_NONINV];
        end else if (user_mode) begin
            cur_invasive_en    = lv[`DAG_LVL_S_INV] |
                                 (lv[`DAG_LVL_NS_INV] & secure_user_invasive_permit);
            cur_noninvasive_en = lv[`DAG_LVL_S_NONINV] |
                                 (lv[`DAG_LVL_NS_NONINV] &
                                  (secure_user_noninvasive_permit | secure_user_invasive_permit));
        end else begin
            cur_invasive_en    = lv[`DAG_LVL_S_INV];
            cur_noninvasive_en = lv[`DAG_LVL_S_NONINV];
        end
    end

    // Sampled level vector one edge after the inputs
    property p_sample_follows;
        @(posedge core_clk) disable iff (!arst_n)
        (MODE == dag_pkg::DAG_MODE_SYNC) && valid_q |=> (lv == $past(raw_lv));
    endproperty
    a_sample_follows: assert property (p_sample_follows) else $error("level enables lag inputs wrongly");

    property p_inv_forces_nin;
        @(posedge core_clk) disable iff (!arst_n)
        ns_invasive_en |-> ns_noninvasive_en;
    endproperty
    a_inv_forces_nin: assert property (p_inv_forces_nin) else $error("invasive without non-invasive");

    property p_sinv_forces_snin;
        @(posedge core_clk) disable iff (!arst_n)
        s_invasive_en |-> s_noninvasive_en;
    endproperty
    a_sinv_forces_snin: assert property (p_sinv_forces_snin) else $error("secure non-invasive not forced");

    property p_no_inv;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && valid_q && !invasive_permit_in |=> !ns_invasive_en && !s_invasive_en;
    endproperty
    a_no_inv: assert property (p_no_inv) else $error("invasive debug enabled while forbidden");

    property p_no_debug;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && !invasive_permit_in && !noninvasive_permit_in |=> (lv == `DAG_RST_LEVELS);
    endproperty
    a_no_debug: assert property (p_no_debug) else $error("debug enabled with both permits low");

    property p_sinv_and;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && s_invasive_en |-> $past(invasive_permit_in) && $past(secure_invasive_permit_in);
    endproperty
    a_sinv_and: assert property (p_sinv_and) else $error("secure invasive not bounded");

    property p_snin_and;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && s_noninvasive_en |-> ($past(invasive_permit_in) || $past(noninvasive_permit_in)) &&
                                        ($past(secure_invasive_permit_in) || $past(secure_noninvasive_permit_in));
    endproperty
    a_snin_and: assert property (p_snin_and) else $error("secure non-invasive not bounded");

    property p_reset_low;
        @(posedge core_clk)
        (IS_SYNC ? !valid_q : !arst_n) |->
            !ns_invasive_en && !ns_noninvasive_en && !s_invasive_en && !s_noninvasive_en;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("enable raised before first sample");

    property p_priv_secure;
        @(posedge core_clk) disable iff (!arst_n)
        secure_mode && !user_mode |-> (cur_invasive_en == s_invasive_en);
    endproperty
    a_priv_secure: assert property (p_priv_secure) else $error("user setting leaked to privileged mode");

    // Overrides checked against the pins, so a broken OR cannot hide behind the level vector
    property p_inv_overrides;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && invasive_permit_in |=> ns_noninvasive_en;
    endproperty
    a_inv_overrides: assert property (p_inv_overrides) else $error("override of non-invasive missing");

    property p_sinv_overrides;
        @(posedge core_clk) disable iff (!arst_n)
        IS_SYNC && secure_invasive_permit_in && (invasive_permit_in || noninvasive_permit_in) |=> s_noninvasive_en;
    endproperty
    a_sinv_overrides: assert property (p_sinv_overrides) else $error("secure override missing");

    // Unsampled flavour answers in the same cycle, so these checks use no delay
    property p_async_no_inv;
        @(posedge core_clk) disable iff (!arst_n)
        !IS_SYNC && !invasive_permit_in |-> !ns_invasive_en && !s_invasive_en;
    endproperty
    a_async_no_inv: assert property (p_async_no_inv) else $error("async invasive enabled");

    property p_async_no_debug;
        @(posedge core_clk) disable iff (!arst_n)
        !IS_SYNC && !invasive_permit_in && !noninvasive_permit_in |-> (lv == `DAG_RST_LEVELS);
    endproperty
    a_async_no_debug: assert property (p_async_no_debug) else $error("async debug with both permits low");

    property p_async_sinv_and;
        @(posedge core_clk) disable iff (!arst_n)
        !IS_SYNC && s_invasive_en |-> invasive_permit_in && secure_invasive_permit_in;
    endproperty
    a_async_sinv_and: assert property (p_async_sinv_and) else $error("async secure invasive not bounded");

    property p_async_snin_and;
        @(posedge core_clk) disable iff (!arst_n)
        !IS_SYNC && s_noninvasive_en |-> (invasive_permit_in || noninvasive_permit_in) &&
                                         (secure_invasive_permit_in || secure_noninvasive_permit_in);
    endproperty
    a_async_snin_and: assert property (p_async_snin_and) else $error("async secure bound broken");

endmodule // dag_gate

// >>> logic/dag_regs.svh
// Constants for the debug authentication gate: field positions and reset values.
// Assumes inclusion by bare name from the gate module; definitions only.
`ifndef DAG_REGS_SVH
`define DAG_REGS_SVH

// Bit positions of the level enables in the packed level vector
`define DAG_LVL_NS_INV     0
`define DAG_LVL_NS_NONINV  1
`define DAG_LVL_S_INV      2
`define DAG_LVL_S_NONINV   3
`define DAG_LVL_WIDTH      4

// Reset value of the sampled level vector, every level enable and the first-sample marker
`define DAG_RST_LEVELS     4'h0
`define DAG_RST_BIT        1'h0

`endif

// >>> logic/dag_pkg.sv
// Types for the debug authentication gate.
// Assumes nothing beyond a SystemVerilog compiler.
package dag_pkg;

    // Sampling mode of the permission inputs
    typedef enum logic [0:0] {
        DAG_MODE_ASYNC = 1'b0,
        DAG_MODE_SYNC  = 1'b1
    } dag_mode_t;

    // One bit for each debug level
    typedef logic [3:0] dag_levels_t;

endpackage

// >>> test/dag_auth_ctrl.sv
// Model of the system logic that drives the four debug permits.
// Assumes the bench changes its request only just after core_clk edges.
`timescale 1ns/1ps
module dag_auth_ctrl (
    // Clock
    input  wire logic       core_clk,
    // Requested {inv, noninv, s_inv, s_noninv} and leave to drive deprecated sets
    input  wire logic [3:0] req,
    input  wire logic       allow_dep,
    // Permits towards the gate
    output logic      [3:0] permits
);
    logic [3:0] want;

    // Takes the request on the edge, where the bench never moves it, so there is no race;
    // drives just after the edge; without leave it folds a request into a legal set
    initial begin
        permits = 4'h0;
        forever begin
            @(posedge core_clk);
            if (allow_dep) begin
                want = req;
            end else begin
                want = {req[3], req[3] | req[2], req[3] & req[1],
                        (req[3] & req[1]) | (req[0] & (req[3] | req[2]))};
            end
            #2;
            permits = want;
        end
    end
endmodule // dag_auth_ctrl

// >>> test/tb_top.sv
// Self-checking bench for the debug authentication gate, both sampling modes.
// Assumes the sampled gate answers one core_clk cycle after its permits change, the other at once.
`timescale 1ns/1ps
module tb_top;
    logic       core_clk  = 1'b0;
    logic       arst_n    = 1'b0;
    logic [3:0] req       = 4'h0;
    logic       allow_dep = 1'b1;
    logic       sui       = 1'b0;
    logic       sun       = 1'b0;
    logic       sm        = 1'b0;
    logic       um        = 1'b0;
    logic [3:0] pm;
    logic [3:0] lv;
    logic       ci;
    logic       cn;
    logic       sv;
    logic [3:0] lv_a;
    logic       ci_a;
    logic       cn_a;
    logic       sv_a;
    int         miscompares = 0;
    int         n_tests     = 0;

    // Clock, 25 ns period
    initial forever #12.5 core_clk = ~core_clk;

    dag_auth_ctrl u_ctrl (.core_clk(core_clk), .req(req), .allow_dep(allow_dep), .permits(pm));

    dag_gate #(.MODE(dag_pkg::DAG_MODE_SYNC)) dut (
        .core_clk(core_clk), .arst_n(arst_n),
        .invasive_permit_in(pm[3]), .noninvasive_permit_in(pm[2]),
        .secure_invasive_permit_in(pm[1]), .secure_noninvasive_permit_in(pm[0]),
        .secure_user_invasive_permit(sui), .secure_user_noninvasive_permit(sun),
        .secure_mode(sm), .user_mode(um),
        .ns_invasive_en(lv[0]), .ns_noninvasive_en(lv[1]),
        .s_invasive_en(lv[2]), .s_noninvasive_en(lv[3]), .sampled_valid(sv),
        .cur_invasive_en(ci), .cur_noninvasive_en(cn)
    );

    // Unsampled flavour on the same pins, so both modes see identical stimulus
    dag_gate #(.MODE(dag_pkg::DAG_MODE_ASYNC)) dut_async (
        .core_clk(core_clk), .arst_n(arst_n),
        .invasive_permit_in(pm[3]), .noninvasive_permit_in(pm[2]),
        .secure_invasive_permit_in(pm[1]), .secure_noninvasive_permit_in(pm[0]),
        .secure_user_invasive_permit(sui), .secure_user_noninvasive_permit(sun),
        .secure_mode(sm), .user_mode(um),
        .ns_invasive_en(lv_a[0]), .ns_noninvasive_en(lv_a[1]),
        .s_invasive_en(lv_a[2]), .s_noninvasive_en(lv_a[3]), .sampled_valid(sv_a),
        .cur_invasive_en(ci_a), .cur_noninvasive_en(cn_a)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits n edges, then steps off the edge by the drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Level vector {s_nin, s_inv, ns_nin, ns_inv} from {inv, nin, s_inv, s_nin}
    function automatic logic [3:0] f_lv(input logic [3:0] r);
        return {(r[3] | r[2]) & (r[1] | r[0]), r[3] & r[1], r[3] | r[2], r[3]};
    endfunction

    // Enables for the current mode, {noninvasive, invasive}
    function automatic logic [1:0] f_cur(input logic [3:0] l);
        if (!sm)
            return {l[1], l[0]};
        if (!um)
            return {l[3], l[2]};
        return {l[3] | (l[1] & (sun | sui)), l[2] | (l[0] & sui)};
    endfunction

    // Held low for three cycles of reset, valid on the first edge after release, and again mid-run
    task automatic t_reset();
        req = 4'hF;
        tick(3);
        chk({3'h0, sv, lv}, 8'h00);
        chk({3'h0, sv_a, lv_a}, 8'h00);
        arst_n = 1'b1;
        tick(1);
        chk({3'h0, sv, lv}, 8'h1F);
        chk({3'h0, sv_a, lv_a}, 8'h1F);
        arst_n = 1'b0;
        tick(1);
        chk({3'h0, sv, lv}, 8'h00);
        chk({3'h0, sv_a, lv_a}, 8'h00);
        arst_n = 1'b1;
        tick(1);
        chk({3'h0, sv, lv}, 8'h1F);
        chk({3'h0, sv_a, lv_a}, 8'h1F);
    endtask

    // Exactly one cycle from permit change to enable, none unsampled, with a folded request
    task automatic t_latency();
        req = 4'h0;
        tick(3);
        allow_dep = 1'b0;
        req = 4'h8;
        tick(1);
        #1;
        chk({4'h0, lv}, 8'h00);
        chk({4'h0, lv_a}, 8'h03);
        tick(1);
        chk({4'h0, lv}, 8'h03);
        allow_dep = 1'b1;
    endtask

    // Every permit set, deprecated ones included, against every mode and user setting
    task automatic t_matrix();
        logic [7:0] exp_v;
        for (int r = 0; r < 16; r++) begin
            req = r[3:0];
            tick(3);
            for (int m = 0; m < 16; m++) begin
                {sm, um, sui, sun} = m[3:0];
                tick(1);
                exp_v = {2'h0, f_cur(f_lv(r[3:0])), f_lv(r[3:0])};
                chk({2'h0, cn, ci, lv}, exp_v);
                chk({2'h0, cn_a, ci_a, lv_a}, exp_v);
            end
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        t_reset();
        t_latency();
        t_matrix();
        end_of_test();
    end
endmodule // tb_top
